// [common/mmc_params.svh]
// Constants for the memory controller mode control register block.
// Included by the package and the design; definitions only.
`ifndef MMC_PARAMS_SVH
`define MMC_PARAMS_SVH

// ----------------------------------------
// Bit positions in the register word
// ----------------------------------------
`define MMC_B_FDM        15
`define MMC_B_FDM2       14
`define MMC_B_CACHE_SLOW 13
`define MMC_B_TIMER_LONG 12
`define MMC_B_SOFT_LOG   11
`define MMC_B_EPR_HI     10
`define MMC_B_EPR_LO     9
`define MMC_B_REFRESH    8
`define MMC_B_NO_ERR_DET 7
`define MMC_B_NO_PAGE    6
`define MMC_B_FLUSH      5
`define MMC_B_FORCE_HIT  4
`define MMC_B_FORCE_PAR  3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MMC_CTL_RESET    12'h000
`define MMC_CLK_MHZ      250
`define MMC_EPR_T11_NS   1500
`define MMC_EPR_T10_NS   12000
`define MMC_EPR_T01_NS   32000
`define MMC_EPR_T00_NS   910000
`define MMC_EPR_W        18
`define MMC_EPR_11       2'h3
`define MMC_EPR_10       2'h2
`define MMC_EPR_01       2'h1

`endif

// [common/mmc_pkg.sv]
// Types shared by the mode control register block.
// Assumes mmc_params.svh sits on the include path.
`include "mmc_params.svh"

package mmc_pkg;

    // Writable mode bits, most significant register bit first
    typedef struct packed {
        logic fast_diagnostic_mode;
        logic fdm2;
        logic cache_slow;
        logic timer_long;
        logic soft_log;
        logic [1:0] epr_scale;
        logic no_err_det;
        logic no_page;
        logic flush;
        logic force_hit;
        logic force_par;
    } mmc_ctl_t;

    // Register access request
    typedef struct packed {
        logic req;
        logic write;
        logic [31:0] wdata;
    } mmc_acc_t;

    // Response sequencer states
    typedef enum logic [1:0] {
        MMC_ST_IDLE  = 2'b00,
        MMC_ST_FLUSH = 2'b01,
        MMC_ST_SLOW  = 2'b10
    } mmc_state_t;

endpackage

// [hw/mmc_mode_ctrl.sv]
// Mode control and diagnostic status register, bits 15 to 3, with their effects.
// Assumes every event input is a one-cycle pulse from logic on sys_clk.
//
// Summary of operation
// - Fast diagnostic bit drives mode select bit one
// - Second pass bit acts only with diagnostic bit
// - Slow cache bit adds one response cycle
// - Timer select lengthens system interface timers
// - Logging off: correct, no irq, flag lost
// - Logging on: correct, interrupt, log, set status
// - Prescaler picks slow register timeout limit
// - Refresh flag set on refresh, read clears
// - Detection disabled: no correction, log, report
// - Page mode off closes row every transaction
// - Writing flush starts flush, withholds ready
// - Only a write carrying flush stalls until empty
// - Forced hit drains write queues before reads
// - Forced parity inverts both parity checkers
// - System bus I/O parity always ignored
// - Read/write bits cleared by reset
`timescale 1ns/1ns
`default_nettype none
`include "mmc_params.svh"

module mmc_mode_ctrl #(
    parameter int unsigned EPR_CYC_01 = `MMC_EPR_T01_NS * `MMC_CLK_MHZ / 1000,
    parameter int unsigned EPR_CYC_00 = `MMC_EPR_T00_NS * `MMC_CLK_MHZ / 1000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register access port
    input wire mmc_pkg::mmc_acc_t acc,
    output logic [31:0] acc_rdata,
    output logic acc_ready,
    // Queue and memory sequencer status
    input wire logic queues_empty,
    input wire logic refresh_selected,
    input wire logic row_open_req,
    input wire logic mem_busy,
    // Slow register transactions
    input wire logic epr_start,
    input wire logic epr_done,
    // Error and parity events
    input wire logic mem_corr_err,
    input wire logic mem_hard_err,
    input wire logic mem_rd_err,
    input wire logic dma_err,
    input wire logic sys_par_raw,
    input wire logic sys_io_txn,
    input wire logic per_par_raw,
    // Mode outputs
    output logic [1:0] mode_select_out,
    output logic fdm_second_pass,
    output logic timer_count_long,
    output logic flush_start,
    output logic force_hit,
    output logic row_strobe_timing,
    output logic epr_timeout,
    // Error outputs
    output logic ecc_correct_en,
    output logic err_log,
    output logic status_logged_set,
    output logic status_lost_set,
    output logic soft_error_interrupt_n,
    output logic hard_error_interrupt_n,
    output logic bus_error_n,
    output logic peripheral_error_n,
    output logic sys_par_err,
    output logic per_par_err
);

    // ----------------------------------------
    // Timeout limits
    // ----------------------------------------
    localparam logic [`MMC_EPR_W-1:0] EPR_LIM_11 = `MMC_EPR_W'(`MMC_EPR_T11_NS * `MMC_CLK_MHZ / 1000);
    localparam logic [`MMC_EPR_W-1:0] EPR_LIM_10 = `MMC_EPR_W'(`MMC_EPR_T10_NS * `MMC_CLK_MHZ / 1000);

    mmc_pkg::mmc_ctl_t ctl_q, ctl_d;
    mmc_pkg::mmc_state_t st_q, st_d;
    logic refresh_q;
    logic [`MMC_EPR_W-1:0] epr_cnt_q;
    logic epr_run_q;

    // ----------------------------------------
    // Access decode
    // ----------------------------------------
    // A request is taken only while the sequencer is idle and no answer is out
    wire take = acc.req && st_q == mmc_pkg::MMC_ST_IDLE && !acc_ready;
    wire take_wr = take && acc.write;
    wire take_rd = take && !acc.write;
    wire wr_flush = acc.wdata[`MMC_B_FLUSH];
    wire [31:0] read_word = {16'h0000, ctl_q.fast_diagnostic_mode, ctl_q.fdm2, ctl_q.cache_slow, ctl_q.timer_long,
                             ctl_q.soft_log, ctl_q.epr_scale, refresh_q, ctl_q.no_err_det,
                             ctl_q.no_page, ctl_q.flush, ctl_q.force_hit, ctl_q.force_par, 3'h0};
    wire det_on = !ctl_q.no_err_det;

    // Next value of the writable bits
    assign ctl_d = take_wr ? {acc.wdata[`MMC_B_FDM:`MMC_B_EPR_LO],
                              acc.wdata[`MMC_B_NO_ERR_DET:`MMC_B_FORCE_PAR]} : ctl_q;

    // ----------------------------------------
    // Response sequencer
    // ----------------------------------------
    // Flush wait ignores the cycle of the start pulse, so a stale empty cannot answer early
    wire flush_done = queues_empty && !flush_start;
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            mmc_pkg::MMC_ST_IDLE: begin
                if (take_wr && wr_flush) begin
                    st_d = mmc_pkg::MMC_ST_FLUSH;
                end else if (take && ctl_q.cache_slow) begin
                    st_d = mmc_pkg::MMC_ST_SLOW;
                end
            end
            mmc_pkg::MMC_ST_FLUSH: begin
                if (flush_done) begin
                    st_d = ctl_q.cache_slow ? mmc_pkg::MMC_ST_SLOW : mmc_pkg::MMC_ST_IDLE;
                end
            end
            mmc_pkg::MMC_ST_SLOW: begin
                st_d = mmc_pkg::MMC_ST_IDLE;
            end
            default: begin
                st_d = mmc_pkg::MMC_ST_IDLE;
            end
        endcase
    end
    wire respond = (take && !(acc.write && wr_flush) && !ctl_q.cache_slow)
                || (st_q == mmc_pkg::MMC_ST_FLUSH && flush_done && !ctl_q.cache_slow)
                || st_q == mmc_pkg::MMC_ST_SLOW;

    // Register state, cleared by reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= `MMC_CTL_RESET;
            st_q <= mmc_pkg::MMC_ST_IDLE;
            acc_ready <= 1'b0;
            acc_rdata <= 32'h0000_0000;
            flush_start <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            st_q <= st_d;
            acc_ready <= respond;
            acc_rdata <= take ? (acc.write ? 32'h0000_0000 : read_word) : acc_rdata;
            flush_start <= take_wr && wr_flush;
        end
    end

    // ----------------------------------------
    // Refresh flag
    // ----------------------------------------
    // A refresh in the same cycle as the clearing read wins, so it is not lost
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            refresh_q <= 1'b0;
        end else begin
            refresh_q <= refresh_selected || (refresh_q && !take_rd);
        end
    end

    // ----------------------------------------
    // Slow register timeout
    // ----------------------------------------
    wire [`MMC_EPR_W-1:0] epr_lim = ctl_q.epr_scale == `MMC_EPR_11 ? EPR_LIM_11 :
                                    ctl_q.epr_scale == `MMC_EPR_10 ? EPR_LIM_10 :
                                    ctl_q.epr_scale == `MMC_EPR_01 ? `MMC_EPR_W'(EPR_CYC_01) :
                                    `MMC_EPR_W'(EPR_CYC_00);
    wire epr_hit = epr_run_q && !epr_done && epr_cnt_q == epr_lim - `MMC_EPR_W'(1);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            epr_cnt_q <= '0;
            epr_run_q <= 1'b0;
            epr_timeout <= 1'b0;
        end else begin
            epr_run_q <= epr_start || (epr_run_q && !epr_done && !epr_hit);
            epr_cnt_q <= epr_start ? '0 : epr_cnt_q + `MMC_EPR_W'(1);
            epr_timeout <= epr_hit;
        end
    end

    // ----------------------------------------
    // Mode and error outputs
    // ----------------------------------------
    // Everything leaves through a flop; interrupt, bus and peripheral error pins are active-low one-cycle pulses, parity errors active-high
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_select_out <= 2'h0;
            fdm_second_pass <= 1'b0;
            timer_count_long <= 1'b0;
            force_hit <= 1'b0;
            row_strobe_timing <= 1'b0;
            ecc_correct_en <= 1'b0;
            err_log <= 1'b0;
            status_logged_set <= 1'b0;
            status_lost_set <= 1'b0;
            soft_error_interrupt_n <= 1'b1;
            hard_error_interrupt_n <= 1'b1;
            bus_error_n <= 1'b1;
            peripheral_error_n <= 1'b1;
            sys_par_err <= 1'b0;
            per_par_err <= 1'b0;
        end else begin
            mode_select_out <= {ctl_q.fast_diagnostic_mode, 1'b0};
            fdm_second_pass <= ctl_q.fast_diagnostic_mode && ctl_q.fdm2;
            timer_count_long <= ctl_q.timer_long;
            force_hit <= ctl_q.force_hit;
            row_strobe_timing <= row_open_req && (mem_busy || !ctl_q.no_page);
            ecc_correct_en <= det_on;
            err_log <= det_on && ((mem_corr_err && ctl_q.soft_log) || mem_hard_err
                                  || mem_rd_err || dma_err);
            status_logged_set <= det_on && mem_corr_err && ctl_q.soft_log;
            status_lost_set <= det_on && mem_corr_err && !ctl_q.soft_log;
            soft_error_interrupt_n <= !(det_on && mem_corr_err && ctl_q.soft_log);
            hard_error_interrupt_n <= !(det_on && mem_hard_err);
            bus_error_n <= !(det_on && mem_rd_err);
            peripheral_error_n <= !(det_on && dma_err);
            sys_par_err <= !sys_io_txn && (sys_par_raw ^ ctl_q.force_par);
            per_par_err <= per_par_raw ^ ctl_q.force_par;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_FDM_SELECT: assert property (take_wr && acc.wdata[`MMC_B_FDM] |-> ##2 mode_select_out[1])
        else $error("mode select bit one not raised after write");
    AST_FDM2_GATED: assert property (fdm_second_pass |-> $past(ctl_q.fast_diagnostic_mode))
        else $error("second pass active without diagnostic mode");
    AST_SLOW_REPLY: assert property (take && !acc.write && ctl_q.cache_slow |=> !acc_ready ##1 acc_ready)
        else $error("slow cache reply not delayed by one cycle");
    AST_FAST_REPLY: assert property (take && !acc.write && !ctl_q.cache_slow |=> acc_ready)
        else $error("fast cache reply not in next cycle");
    AST_LOST_SOFT: assert property (mem_corr_err && det_on && !ctl_q.soft_log
                                    |=> status_lost_set && soft_error_interrupt_n)
        else $error("lost correctable error not flagged");
    AST_SOFT_IRQ: assert property (mem_corr_err && det_on && ctl_q.soft_log
                                   |=> !soft_error_interrupt_n && status_logged_set && err_log)
        else $error("logged correctable error not reported");
    AST_NO_DETECT: assert property (ctl_q.no_err_det |=> hard_error_interrupt_n && bus_error_n
                                    && !ecc_correct_en)
        else $error("error reported while detection disabled");
    AST_REFRESH_CLR: assert property (take_rd && !refresh_selected |=> !refresh_q)
        else $error("refresh flag survived a read");
    AST_REFRESH_SET: assert property (refresh_selected |=> refresh_q)
        else $error("refresh flag not set");
    AST_FLUSH_STALL: assert property (st_q == mmc_pkg::MMC_ST_FLUSH && !queues_empty
                                      |=> !acc_ready && st_q == mmc_pkg::MMC_ST_FLUSH)
        else $error("ready given while flush pending");
    AST_PAR_IO: assert property (sys_io_txn |=> !sys_par_err)
        else $error("parity error on system bus I/O");
    AST_PAR_FORCE: assert property (ctl_q.force_par && !per_par_raw |=> per_par_err)
        else $error("forced parity not inverted");

endmodule
`default_nettype wire

// [verif/mmc_far_model.sv]
// Far-side model: the write and invalidate queues behind the controller.
// Assumes flush_start is a one-cycle pulse on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module mmc_far_model #(
    parameter int DRAIN = 6
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Controller side
    input wire logic flush_start,
    output logic queues_empty
);
    int cnt_q;
    // --------------------------------
    // Queue drain
    // --------------------------------
    // Queues stay busy DRAIN cycles after a flush, so an early answer shows
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 0;
        end else if (flush_start) begin
            cnt_q <= DRAIN;
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    assign queues_empty = (cnt_q == 0);
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the mode control register block.
// Assumes the package and the far-side queue model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int DRAIN = 6;
    logic sys_clk, resetn, acc_ready, queues_empty, refresh_selected, row_open_req, mem_busy;
    logic epr_start, mem_corr_err, mem_hard_err, mem_rd_err, dma_err, sys_par_raw, sys_io_txn, per_par_raw;
    logic fdm_second_pass, timer_count_long, flush_start, force_hit, row_strobe_timing, epr_timeout;
    logic ecc_correct_en, err_log, status_logged_set, status_lost_set, sys_par_err, per_par_err;
    logic soft_error_interrupt_n, hard_error_interrupt_n, bus_error_n, peripheral_error_n;
    logic [1:0] mode_select_out;
    logic [31:0] acc_rdata, lat, w, q;
    mmc_pkg::mmc_acc_t acc;
    int failures, total_checks;
    // Small timeout counts keep the slow codes short
    mmc_mode_ctrl #(.EPR_CYC_01(20), .EPR_CYC_00(40)) i_mmc_mode_ctrl (
        .sys_clk(sys_clk), .resetn(resetn), .acc(acc), .acc_rdata(acc_rdata), .acc_ready(acc_ready),
        .queues_empty(queues_empty), .refresh_selected(refresh_selected), .row_open_req(row_open_req),
        .mem_busy(mem_busy), .epr_start(epr_start), .epr_done(1'b0), .mem_corr_err(mem_corr_err),
        .mem_hard_err(mem_hard_err), .mem_rd_err(mem_rd_err), .dma_err(dma_err), .sys_par_raw(sys_par_raw),
        .sys_io_txn(sys_io_txn), .per_par_raw(per_par_raw), .mode_select_out(mode_select_out),
        .fdm_second_pass(fdm_second_pass), .timer_count_long(timer_count_long), .flush_start(flush_start),
        .force_hit(force_hit), .row_strobe_timing(row_strobe_timing), .epr_timeout(epr_timeout),
        .ecc_correct_en(ecc_correct_en), .err_log(err_log), .status_logged_set(status_logged_set),
        .status_lost_set(status_lost_set), .soft_error_interrupt_n(soft_error_interrupt_n),
        .hard_error_interrupt_n(hard_error_interrupt_n), .bus_error_n(bus_error_n),
        .peripheral_error_n(peripheral_error_n), .sys_par_err(sys_par_err), .per_par_err(per_par_err));
    mmc_far_model #(.DRAIN(DRAIN)) i_mmc_far_model (
        .sys_clk(sys_clk), .resetn(resetn), .flush_start(flush_start), .queues_empty(queues_empty));
    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Request held through the edge that samples ready high, dropped after it; lat counts cycles after take
    task automatic access(input logic wr, input logic [31:0] d);
        int n;
        @(negedge sys_clk);
        acc = '{req: 1'b1, write: wr, wdata: d};
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (acc_ready !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            failures++;
            $display("Error at %0t: no ready", $time);
            summarize();
        end
        lat = n;
        q = acc_rdata;
        @(negedge sys_clk);
        acc.req = 1'b0;
    endtask
    // Pulse stands one cycle; its registered effect is settled at the next falling edge
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask
    function automatic logic [31:0] exp_rd(input logic [31:0] v, input logic rf);
        return {16'h0000, v[15:9], rf, v[7:3], 3'h0};
    endfunction
    // --------------------------------
    // Clock and main sequence
    // --------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        int d;
        int unsigned lim [4];
        logic slow;
        lim = '{40, 20, 3000, 375};
        {resetn, refresh_selected, row_open_req, mem_busy, epr_start, mem_corr_err} = 6'h00;
        {mem_hard_err, mem_rd_err, dma_err, sys_par_raw, sys_io_txn, per_par_raw} = 6'h00;
        slow = 1'b0;
        acc = '0;
        failures = 0;
        total_checks = 0;
        void'($urandom(32'hC58FF1B2));
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        access(1'b0, 32'h0);
        chk(q, 32'h0, "reset read");
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            w = $urandom & 32'hFFFFFFDF;
            {row_open_req, mem_busy} = 2'($urandom);
            access(1'b1, w);
            chk(lat, 32'(1 + slow), "write latency");
            access(1'b0, 32'h0);
            chk(q, exp_rd(w, 1'b0), "readback");
            chk(lat, 32'(1 + w[13]), "read latency");
            chk({27'h0, mode_select_out, fdm_second_pass, timer_count_long, force_hit},
                {27'h0, w[15], 1'b0, w[15] & w[14], w[12], w[4]}, "mode outputs");
            chk({31'h0, row_strobe_timing}, {31'h0, row_open_req & (mem_busy | !w[6])}, "row strobe");
            // The write's own timing follows the speed bit in force before it lands
            slow = w[13];
        end
        $display("test random done");
        access(1'b1, 32'h0);
        pulse(refresh_selected);
        access(1'b0, 32'h0);
        chk(q, 32'h100, "refresh set");
        access(1'b0, 32'h0);
        chk(q, 32'h0, "refresh cleared by read");
        $display("test refresh done");
        for (int m = 0; m < 4; m++) begin
            access(1'b1, (32'(m & 1) << 11) | (32'(m >> 1) << 7));
            pulse(mem_corr_err);
            d = (m == 1) ? 5'h16 : ((m == 0) ? 5'h19 : 5'h08);
            chk({27'h0, ecc_correct_en, soft_error_interrupt_n, err_log, status_logged_set, status_lost_set},
                32'(d), "soft error");
            @(negedge sys_clk);
            {mem_hard_err, mem_rd_err, dma_err} = 3'h7;
            @(negedge sys_clk);
            {mem_hard_err, mem_rd_err, dma_err} = 3'h0;
            d = (m >= 2) ? 4'h7 : 4'h8;
            chk({28'h0, err_log, hard_error_interrupt_n, bus_error_n, peripheral_error_n}, 32'(d),
                "hard errors");
        end
        $display("test errors done");
        for (int k = 0; k < 8; k++) begin
            access(1'b1, 32'(k & 1) << 3);
            {sys_io_txn, sys_par_raw, per_par_raw} = {k[2], k[1], k[1]};
            @(negedge sys_clk);
            chk({31'h0, sys_par_err}, {31'h0, !k[2] & (k[1] ^ k[0])}, "system parity");
            chk({31'h0, per_par_err}, {31'h0, k[1] ^ k[0]}, "peripheral parity");
        end
        {sys_io_txn, sys_par_raw, per_par_raw} = 3'h0;
        $display("test parity done");
        repeat (2) begin
            access(1'b1, 32'h20);
            chk({31'h0, lat >= DRAIN + 2 && lat <= DRAIN + 4}, 32'h1, "flush stall");
            chk({31'h0, queues_empty}, 32'h1, "queues empty at ready");
        end
        access(1'b1, 32'h0);
        chk(lat, 32'h1, "flush cleared");
        $display("test flush done");
        for (int c = 0; c < 4; c++) begin
            access(1'b1, 32'(c) << 9);
            pulse(epr_start);
            d = 0;
            while (epr_timeout !== 1'b1 && d < 4000) begin
                @(negedge sys_clk);
                d++;
            end
            chk(32'(d), 32'(lim[c]), "slow register timeout");
            if (d >= 4000) summarize();
        end
        $display("test timeout done");
        access(1'b1, 32'hFFF8); // Timer select set, as a 4 ns clock wants
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        access(1'b0, 32'h0);
        chk(q, 32'h0, "mid-run reset");
        $display("test rereset done");
        summarize();
    end
endmodule
`default_nettype wire
